/* core/image_map_pkg.sv */
// Constants and types shared by the process-image mapping block
`default_nettype none

package image_map_pkg;

  // ----------------------------------------------------------------
  // Link occupation and image geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] STATIONS   = 3'h4;
  localparam int         NUM_WORDS  = 16;
  localparam int         WORD_W     = 16;
  localparam int         IMAGE_W    = NUM_WORDS * WORD_W;
  localparam int         SLOT_W     = 128;
  localparam logic [4:0] SCAN_LAST  = 5'h10;

  // ----------------------------------------------------------------
  // Host-to-remote control bit positions
  // ----------------------------------------------------------------
  localparam int BIT_OFFLINE = 0;
  localparam int BIT_AUTOADR = 1;
  localparam int BIT_CFGMODE = 2;
  localparam int BIT_PROTECT = 3;
  localparam int BIT_SELECT  = 4;
  localparam int BIT_BUF_N   = 5;
  localparam logic [15:0] CTRL_MASK = 16'h003f;

  // ----------------------------------------------------------------
  // Remote-to-host acknowledge bit positions and reset values
  // ----------------------------------------------------------------
  localparam int   ACK_SELECT     = 4;
  localparam int   ACK_BUF        = 5;
  localparam logic RST_SELECT_ACK = 1'b0;
  localparam logic RST_BUF_ACK    = 1'b1;
  localparam logic RST_BUF_N      = 1'b1;

  // ----------------------------------------------------------------
  // Image scan sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN  = 2'b10
  } scan_e;

endpackage : image_map_pkg

`default_nettype wire

/* core/resp_mem_if.sv */
// Port bundle between the mapping core and the response memory
`timescale 1ns/1ps
`default_nettype none

interface resp_mem_if #(
  parameter int AW = 4,
  parameter int DW = 16
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface : resp_mem_if

`default_nettype wire

/* core/resp_mem.sv */
// Mailbox response word store with registered read data
`timescale 1ns/1ps
`default_nettype none

module resp_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input  wire logic sys_clk,  // System clock
  resp_mem_if.mem   port      // Write and read ports
);

  logic [DW-1:0] store [2**AW];

  // ----------------------------------------------------------------
  // Write and registered read; no reset so it maps onto RAM
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end

endmodule : resp_mem

`default_nettype wire

/* core/fieldbus_process_image_map.sv */
// Cyclic process-image mapping between host link and AS-i master
`timescale 1ns/1ps
`default_nettype none

module fieldbus_process_image_map (
  input  wire logic         sys_clk,          // System clock, 10 MHz
  input  wire logic         rstn,             // Sync reset, active low
  input  wire logic [15:0]  host_to_remote_bits, // Host control bits
  input  wire logic         link_refresh,     // Cyclic refresh strobe
  input  wire logic [255:0] write_words,      // Host write word area
  input  wire logic         msg_req,          // Acyclic message attempt
  input  wire logic [127:0] slave_in_a,       // Single/A inputs, slot 0 unused
  input  wire logic [127:0] slave_in_b,       // B inputs, slot 0 unused
  input  wire logic         cfg_error,        // Configuration error seen
  input  wire logic         power_ok,         // AS-i power good
  input  wire logic         normal_op,        // Normal operation active
  input  wire logic         protected_active, // Protected mode active
  input  wire logic         resp_we,          // Mailbox response write
  input  wire logic [3:0]   resp_addr,        // Response word index
  input  wire logic [15:0]  resp_data,        // Response word data
  output logic [15:0]       remote_to_host_bits, // Acknowledge bits
  output logic [255:0]      read_words,       // Host read word area
  output logic              force_offline,    // Master held offline
  output logic              auto_addressing_enable, // Auto address ok
  output logic              config_mode_pulse,  // Enter config mode
  output logic              protect_mode_pulse, // Enter protected mode
  output logic [127:0]      slave_out_a,      // Single/A output nibbles
  output logic [127:0]      slave_out_b,      // B output nibbles
  output logic [255:0]      mbx_request,      // Mailbox request words
  output logic              mbx_req_stb,      // New mailbox request
  output logic              msg_reject,       // Message attempt refused
  output logic [2:0]        occupied_stations // Stations taken on link
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    image_map_pkg::scan_e st;
    logic [4:0]           idx;
    logic                 sel;
    logic                 buf_n;
    logic [5:0]           prev;
    logic                 offline;
    logic                 autoadr;
    logic                 cfg_pls;
    logic                 prot_pls;
    logic                 sel_ack;
    logic                 buf_ack;
    logic                 req_stb;
    logic                 reject;
    logic [2:0]           stations;
    logic [255:0]         rd_img;
    logic [127:0]         out_a;
    logic [127:0]         out_b;
    logic [255:0]         req;
  } state_s;

  state_s s_q;
  state_s s_d;

  resp_mem_if #(.AW(4), .DW(16)) mem_bus ();

  logic [3:0]   flags;
  logic [255:0] io_image;
  logic [5:0]   ctrl;

  // ----------------------------------------------------------------
  // Response memory; the mailbox engine fills it at its own pace
  // ----------------------------------------------------------------
  assign mem_bus.we    = resp_we;
  assign mem_bus.waddr = resp_addr;
  assign mem_bus.wdata = resp_data;
  assign mem_bus.raddr = s_q.idx[3:0];

  resp_mem #(.AW(4), .DW(16)) u_resp_mem (
    .sys_clk (sys_clk),
    .port    (mem_bus)
  );

  // ----------------------------------------------------------------
  // Input image: flags, then A slaves, then B with slot 0 blank
  // ----------------------------------------------------------------
  assign flags = {~protected_active, ~normal_op, ~power_ok,
                  cfg_error};
  assign io_image = {slave_in_b[127:4], 4'h0,
                     slave_in_a[127:4], flags};
  // Reserved control bits are simply never looked at
  assign ctrl = host_to_remote_bits[5:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [3:0]  w;
    logic [15:0] word;
    w    = 4'h0;
    word = 16'h0000;
    s_d  = s_q;
    s_d.stations = image_map_pkg::STATIONS;
    s_d.reject   = msg_req;
    s_d.req_stb  = 1'b0;
    // Control levels follow the host bits directly
    s_d.offline = ctrl[image_map_pkg::BIT_OFFLINE];
    s_d.autoadr = ctrl[image_map_pkg::BIT_AUTOADR];
    // Only the edge matters; a held level gives one pulse
    s_d.cfg_pls = ctrl[image_map_pkg::BIT_CFGMODE]
                  & ~s_q.prev[image_map_pkg::BIT_CFGMODE];
    s_d.prot_pls = ctrl[image_map_pkg::BIT_PROTECT]
                   & ~s_q.prev[image_map_pkg::BIT_PROTECT];
    s_d.prev = ctrl;
    case (s_q.st)
      image_map_pkg::SCAN_IDLE:
      begin
        if (link_refresh)
        begin
          // Mode is frozen for the whole scan so one image is coherent
          s_d.sel   = ctrl[image_map_pkg::BIT_SELECT];
          s_d.buf_n = ctrl[image_map_pkg::BIT_BUF_N];
          s_d.idx   = 5'h00;
          s_d.st    = image_map_pkg::SCAN_RUN;
          if (!ctrl[image_map_pkg::BIT_BUF_N])
          begin
            if (ctrl[image_map_pkg::BIT_SELECT])
            begin
              s_d.req     = write_words;
              s_d.req_stb = 1'b1;
            end
            else
            begin
              s_d.out_a = {write_words[127:4], 4'h0};
              s_d.out_b = {write_words[255:132], 4'h0};
            end
          end
        end
      end
      image_map_pkg::SCAN_RUN:
      begin
        s_d.idx = s_q.idx + 5'h01;
        // Memory data lag the address by one cycle
        if (s_q.idx != 5'h00)
        begin
          w = s_q.idx[3:0] - 4'h1;
          if (s_q.buf_n)
          begin
            word = 16'h0000;
          end
          else if (s_q.sel)
          begin
            word = mem_bus.rdata;
          end
          else
          begin
            word = io_image[{w, 4'h0} +: 16];
          end
          s_d.rd_img[{w, 4'h0} +: 16] = word;
        end
        if (s_q.idx == image_map_pkg::SCAN_LAST)
        begin
          // Acks move only once the whole image matches the mode
          s_d.sel_ack = s_q.sel;
          s_d.buf_ack = s_q.buf_n;
          s_d.st      = image_map_pkg::SCAN_IDLE;
        end
      end
      default:
      begin
        s_d.st = image_map_pkg::SCAN_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s_q          <= '0;
      s_q.st       <= image_map_pkg::SCAN_IDLE;
      s_q.buf_n    <= image_map_pkg::RST_BUF_N;
      s_q.sel_ack  <= image_map_pkg::RST_SELECT_ACK;
      s_q.buf_ack  <= image_map_pkg::RST_BUF_ACK;
      s_q.stations <= image_map_pkg::STATIONS;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state record
  // ----------------------------------------------------------------
  always_comb
  begin
    remote_to_host_bits = 16'h0000;
    remote_to_host_bits[image_map_pkg::ACK_SELECT] = s_q.sel_ack;
    remote_to_host_bits[image_map_pkg::ACK_BUF]    = s_q.buf_ack;
  end

  assign read_words             = s_q.rd_img;
  assign force_offline          = s_q.offline;
  assign auto_addressing_enable = s_q.autoadr;
  assign config_mode_pulse      = s_q.cfg_pls;
  assign protect_mode_pulse     = s_q.prot_pls;
  assign slave_out_a            = s_q.out_a;
  assign slave_out_b            = s_q.out_b;
  assign mbx_request            = s_q.req;
  assign mbx_req_stb            = s_q.req_stb;
  assign msg_reject             = s_q.reject;
  assign occupied_stations      = s_q.stations;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic scan_start;
  logic first_word;
  assign scan_start = link_refresh
                      && (s_q.st == image_map_pkg::SCAN_IDLE);
  assign first_word = (s_q.st == image_map_pkg::SCAN_RUN)
                      && (s_q.idx == 5'h01);

  // Scan cycle that writes word 8, whose low nibble has no slave
  logic b_word;
  assign b_word = (s_q.st == image_map_pkg::SCAN_RUN)
                  && (s_q.idx == 5'h09);

  logic content_select_ack_w;
  assign content_select_ack_w = remote_to_host_bits[4];

  chk_station_count: assert property (
    occupied_stations == 3'h4)
    else $error("station count wrong");

  chk_msg_refuse: assert property (
    msg_req |=> msg_reject)
    else $error("message attempt not refused");

  chk_cfg_edge: assert property (
    (host_to_remote_bits[2] && !s_q.prev[2]) |=> config_mode_pulse
      ##1 (!config_mode_pulse || $rose(host_to_remote_bits[2])))
    else $error("config pulse wrong");

  // Held level must not give a second pulse
  chk_cfg_hold: assert property (
    (host_to_remote_bits[2] && s_q.prev[2]) |=> !config_mode_pulse)
    else $error("config pulse on held level");

  chk_prot_edge: assert property (
    (host_to_remote_bits[3] && !s_q.prev[3]) |=> protect_mode_pulse)
    else $error("protect pulse missing");

  // A held protect level must not retrigger the master
  chk_prot_hold: assert property (
    (host_to_remote_bits[3] && s_q.prev[3]) |=> !protect_mode_pulse)
    else $error("protect pulse on held level");

  chk_sel_ack: assert property (
    scan_start |-> ##18 (content_select_ack_w
      == $past(host_to_remote_bits[4], 18)))
    else $error("select ack wrong");

  chk_buf_ack: assert property (
    scan_start |-> ##18 (remote_to_host_bits[5]
      == $past(host_to_remote_bits[5], 18)))
    else $error("buffer ack wrong");

  chk_io_flags: assert property (
    (first_word && !s_q.sel && !s_q.buf_n)
      |=> read_words[3:0] == $past(flags))
    else $error("flags nibble wrong");

  chk_mbx_word0: assert property (
    (first_word && s_q.sel && !s_q.buf_n)
      |=> read_words[15:0] == $past(mem_bus.rdata))
    else $error("mailbox word zero wrong");

  chk_buf_off: assert property (
    (first_word && s_q.buf_n) |=> read_words[15:0] == 16'h0000)
    else $error("disabled area not blank");

  // Strobe only for a mailbox scan with the area enabled
  chk_mbx_strobe: assert property (
    (scan_start && host_to_remote_bits[4] && !host_to_remote_bits[5])
      |=> mbx_req_stb)
    else $error("mailbox strobe missing");

  chk_io_no_strobe: assert property (
    (scan_start && !host_to_remote_bits[4]) |=> !mbx_req_stb)
    else $error("strobe in IO data mode");

  chk_b_slot_blank: assert property (
    (b_word && !s_q.sel && !s_q.buf_n) |=> read_words[131:128] == 4'h0)
    else $error("unused B nibble not blank");

  chk_offline: assert property (
    ##1 force_offline == $past(host_to_remote_bits[0]))
    else $error("offline level wrong");

  // Levels follow the host one cycle late
  chk_auto_addr: assert property (
    ##1 auto_addressing_enable == $past(host_to_remote_bits[1]))
    else $error("auto address level wrong");

  chk_reserved: assert property (
    (remote_to_host_bits & 16'hffcf) == 16'h0000)
    else $error("reserved bit set");

  cov_io_scan: cover property (
    scan_start && !host_to_remote_bits[4] && !host_to_remote_bits[5]);
  cov_mbx_scan: cover property (
    scan_start && host_to_remote_bits[4] && !host_to_remote_bits[5]);
  cov_cfg_pulse: cover property (config_mode_pulse);
  cov_off_scan: cover property (
    scan_start && host_to_remote_bits[5]);

endmodule : fieldbus_process_image_map

`default_nettype wire

/* dv/host_link_model.sv */
// Behavioural host controller driving the cyclic link image
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
  input  wire logic         sys_clk,             // System clock
  input  wire logic [15:0]  remote_to_host_bits, // Acknowledge bits
  output logic      [15:0]  host_to_remote_bits, // Control bits
  output logic              link_refresh,        // Refresh strobe
  output logic      [255:0] write_words          // Write word area
);
  // Idle: buffer disabled, no refresh strobe and a cleared write area
  initial
  begin
    host_to_remote_bits = 16'h0020;
    link_refresh        = 1'b0;
    write_words         = '0;
  end

  // Change control bits alone, outside any scan
  task automatic put(input logic [15:0] v);
    @(posedge sys_clk);
    host_to_remote_bits <= v;
  endtask : put

  // One refresh, then wait for the acks to follow the new bits
  task automatic scan(input logic [15:0] v, input logic [255:0] ww,
                      output bit ok);
    ok = 1'b0;
    @(posedge sys_clk);
    host_to_remote_bits <= v;
    write_words         <= ww;
    link_refresh        <= 1'b1;
    @(posedge sys_clk);
    link_refresh <= 1'b0;
    // Stale area inverted, so only the refresh-time copy may be used
    write_words  <= ~ww;
    // Spacing also keeps the next refresh out of the running scan
    repeat (18) @(posedge sys_clk);
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(posedge sys_clk);
      ok = (remote_to_host_bits[5:4] === v[5:4]);
    end
  endtask : scan
endmodule : host_link_model

`default_nettype wire

/* dv/test_fieldbus_process_image_map.sv */
// Self-checking bench for the process-image mapping block
`timescale 1ns/1ps
`default_nettype none

module test_fieldbus_process_image_map;
  localparam logic [127:0] IN_A = 128'h0123456789abcdeffedcba9876543210;
  localparam logic [127:0] IN_B = 128'h13579bdf02468ace_8badf00d5eed1e55;

  logic         sys_clk, rstn, link_refresh, msg_req;
  logic [15:0]  host_to_remote_bits, remote_to_host_bits, resp_data;
  logic [255:0] write_words, read_words, mbx_request, mexp;
  logic [127:0] slave_in_a, slave_in_b, slave_out_a, slave_out_b;
  logic         cfg_error, power_ok, normal_op, protected_active;
  logic         resp_we, mbx_req_stb, msg_reject;
  logic [3:0]   resp_addr;
  logic         force_offline, auto_addressing_enable;
  logic         config_mode_pulse, protect_mode_pulse;
  logic [2:0]   occupied_stations;
  int           errors, check_count, stb_count;

  fieldbus_process_image_map dut (.sys_clk(sys_clk), .rstn(rstn),
    .host_to_remote_bits(host_to_remote_bits),
    .link_refresh(link_refresh), .write_words(write_words),
    .msg_req(msg_req), .slave_in_a(slave_in_a), .slave_in_b(slave_in_b),
    .cfg_error(cfg_error), .power_ok(power_ok), .normal_op(normal_op),
    .protected_active(protected_active), .resp_we(resp_we),
    .resp_addr(resp_addr), .resp_data(resp_data),
    .remote_to_host_bits(remote_to_host_bits), .read_words(read_words),
    .force_offline(force_offline),
    .auto_addressing_enable(auto_addressing_enable),
    .config_mode_pulse(config_mode_pulse),
    .protect_mode_pulse(protect_mode_pulse),
    .slave_out_a(slave_out_a), .slave_out_b(slave_out_b),
    .mbx_request(mbx_request), .mbx_req_stb(mbx_req_stb),
    .msg_reject(msg_reject), .occupied_stations(occupied_stations));

  host_link_model p (.sys_clk(sys_clk),
    .remote_to_host_bits(remote_to_host_bits),
    .host_to_remote_bits(host_to_remote_bits),
    .link_refresh(link_refresh), .write_words(write_words));

  // 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Count mailbox strobes; each one must be a single cycle
  always @(posedge sys_clk)
    if (mbx_req_stb === 1'b1)
      stb_count++;

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [255:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Scan wrapper; an ack that never follows ends the run
  task automatic run_scan(input logic [15:0] v, input logic [255:0] ww);
    bit ok;
    p.scan(v, ww, ok);
    if (!ok)
    begin
      errors++;
      report_and_stop();
    end
  endtask : run_scan

  // Expected input image: flags, A slaves 1-31, B slaves 1-31
  function automatic logic [255:0] io_image(input logic [127:0] a, b,
                                            input logic [3:0] f);
    logic [255:0] r;
    r = '0;
    for (int s = 1; s < 32; s++)
    begin
      r[4*s +: 4]       = a[4*s +: 4];
      r[128 + 4*s +: 4] = b[4*s +: 4];
    end
    r[3:0] = f;
    return r;
  endfunction : io_image

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    logic [3:0] st;
    errors = 0;
    check_count = 0;
    stb_count = 0;
    rstn = 1'b0;
    msg_req = 1'b0;
    {slave_in_a, slave_in_b} = {IN_A, IN_B};
    {protected_active, normal_op, power_ok, cfg_error} = 4'b1011;
    {resp_we, resp_addr, resp_data} = '0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    check("stations", occupied_stations, 3'h4);
    check("ack reset", remote_to_host_bits, 16'h0020);
    check("image reset", read_words, '0);
    @(posedge sys_clk);
    // Control levels and edges, reserved bits set alongside
    p.put(16'hffc7);
    @(posedge sys_clk);
    #1;
    check("ctrl a", {force_offline, auto_addressing_enable,
      config_mode_pulse, protect_mode_pulse}, 4'b1110);
    @(posedge sys_clk);
    #1;
    check("ctrl b", {force_offline, auto_addressing_enable,
      config_mode_pulse, protect_mode_pulse}, 4'b1100);
    p.put(16'h000c);
    @(posedge sys_clk);
    #1;
    check("ctrl c", {force_offline, auto_addressing_enable,
      config_mode_pulse, protect_mode_pulse}, 4'b0001);
    check("ack idle", remote_to_host_bits, 16'h0020);
    @(posedge sys_clk);
    #1;
    check("prot end", protect_mode_pulse, 1'b0);
    // Acyclic message attempt
    @(posedge sys_clk);
    msg_req <= 1'b1;
    @(posedge sys_clk);
    msg_req <= 1'b0;
    #1;
    check("msg ref", msg_reject, 1'b1);
    @(posedge sys_clk);
    #1;
    check("msg end", msg_reject, 1'b0);
    // IO data mode, both polarities of every status flag
    for (int i = 0; i < 2; i++)
    begin
      st = i ? 4'b0100 : 4'b1011;
      @(posedge sys_clk);
      {protected_active, normal_op, power_ok, cfg_error} <= st;
      slave_in_a <= i ? ~IN_A : IN_A;
      run_scan(16'h0000, {IN_A, IN_B});
      check("io image", read_words, io_image(i ? ~IN_A : IN_A, IN_B,
        {~st[3], ~st[2], ~st[1], st[0]}));
      check("ack io", remote_to_host_bits, 16'h0000);
      check("out a", slave_out_a, {IN_B[127:4], 4'h0});
      check("out b", slave_out_b, {IN_A[127:4], 4'h0});
    end
    check("no stb", stb_count, 0);
    // Mailbox mode: load response words, then scan
    for (int k = 0; k < 16; k++)
    begin
      @(posedge sys_clk);
      resp_we   <= 1'b1;
      resp_addr <= 4'(k);
      resp_data <= k ? {8'(2*k), 8'(2*k-1)} : 16'h035c;
      mexp[16*k +: 16] = k ? {8'(2*k), 8'(2*k-1)} : 16'h035c;
    end
    @(posedge sys_clk);
    resp_we <= 1'b0;
    run_scan(16'h0010, {IN_B, ~IN_A});
    check("mbx image", read_words, mexp);
    check("ack mbx", remote_to_host_bits, 16'h0010);
    check("mbx req", mbx_request, {IN_B, ~IN_A});
    check("one stb", stb_count, 1);
    // Buffer disabled: area cleared, requests frozen
    run_scan(16'h0030, {IN_A, IN_B});
    check("off image", read_words, '0);
    check("ack off", remote_to_host_bits, 16'h0030);
    check("frozen", mbx_request, {IN_B, ~IN_A});
    check("stb kept", stb_count, 1);
    report_and_stop();
  end
endmodule : test_fieldbus_process_image_map

`default_nettype wire
